// [hw/prf_consts.svh]
// Register offsets, field positions and reset values of the physical request filter block
`ifndef PRF_CONSTS_SVH
`define PRF_CONSTS_SVH
`define PRF_OFS_FILT_SET   12'h118
`define PRF_OFS_FILT_CLR   12'h11C
`define PRF_OFS_UPPER      12'h120
`define PRF_OFS_CTX_SET    12'h180
`define PRF_OFS_CTX_CLR    12'h184
`define PRF_OFS_IRQ_STAT   12'h130
`define PRF_OFS_IRQ_MASK   12'h134
`define PRF_BIT_RUN        15
`define PRF_BIT_WAKE       12
`define PRF_BIT_DEAD       11
`define PRF_BIT_ACTIVE     10
`define PRF_SPD_HI         7
`define PRF_SPD_LO         5
`define PRF_EVT_HI         4
`define PRF_EVT_LO         0
`define PRF_FILT_RST       32'h0000_0000
`define PRF_CTX_WMASK      32'h0000_9000
`define PRF_IRQ_PHYS       0
`define PRF_IRQ_ASYNC      1
`define PRF_IRQ_DEAD       2
`define PRF_IRQ_FETCH      3
`endif

// [hw/prf_filter.sv]
// Physical request filter low, upper bound stub and async context control over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
`include "prf_consts.svh"

// How it works
// RULE1 - Requests for physical context, already past async filter, recheck sender node here.
// RULE2 - Filter bit zero for sender: request goes to asynchronous request context.
// RULE3 - Filter bit n enables physical service for local node n, 0 to 31.
// RULE4 - Write ones at 118h sets, ones at 11Ch clears; resets to zero.
// RULE5 - Upper bound register at 120h reads zero, writes ignored.
// RULE6 - Context control set/clear register commands and reports; upper half reads zero.
// RULE7 - Reads at set or clear address return filter; zero bits change nothing.
// RULE8 - Bit 15 run set and cleared by software; device changes it only on reset.
// RULE9 - Bit 12 wake set by software, cleared by device at each descriptor fetch.
// RULE10 - Bit 11 dead set on fatal error, cleared when run cleared; bit 10 active.
// RULE11 - Bits 7:5 report speed, bits 4:0 hold acknowledge or error code.
module prf_filter
	import prf_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	// AHB-Lite slave
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP,
	// Received request check
	input  wire logic        I_REQ_VLD,
	input  wire logic [5:0]  I_REQ_NODE,
	input  wire logic        I_REQ_ASYNC_OK,
	output logic             O_ROUTE_VLD,
	output logic             O_ROUTE_PHYS,
	// Context engine status
	input  wire logic        I_DESC_FETCH,
	input  wire logic        I_FATAL_ERR,
	input  wire logic        I_ACTIVE,
	input  wire logic        I_PKT_DONE,
	input  wire logic [2:0]  I_PKT_SPD,
	input  wire logic [4:0]  I_PKT_EVT,
	output logic             O_CTX_RUN,
	output logic             O_CTX_WAKE,
	// Interrupt
	output logic             O_IRQ
);

	prf_state_t st_ff;
	prf_state_t nxt_st;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] ctx_word(input prf_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`PRF_BIT_RUN]             = s.run;
		w[`PRF_BIT_WAKE]            = s.wake;
		w[`PRF_BIT_DEAD]            = s.dead;
		w[`PRF_BIT_ACTIVE]          = s.active;
		w[`PRF_SPD_HI:`PRF_SPD_LO]  = s.spd;
		w[`PRF_EVT_HI:`PRF_EVT_LO]  = s.evt;
		return w;
	endfunction : ctx_word

	function automatic logic dph_wr_hit(input prf_state_t s, input logic [11:0] ofs);
		return (s.bus_st == PRF_ST_DATA) && s.wr && (s.addr == ofs);
	endfunction : dph_wr_hit

	logic        addr_ph;
	logic        node_ok;
	logic [31:0] wset;
	logic [31:0] wclr;
	logic [31:0] rd_val;
	logic [3:0]  ev;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st  = st_ff;
		addr_ph = I_HSEL && I_HREADY && I_HTRANS[1];
		wset    = 32'h0000_0000;
		wclr    = 32'h0000_0000;
		rd_val  = 32'h0000_0000;
		ev      = 4'h0;
		// Nodes 32 and above belong to the high filter, never accepted here
		node_ok = (I_REQ_NODE[5] == 1'b0) && st_ff.filt[I_REQ_NODE[4:0]];

		// Bus: zero wait states, write data applied in data phase
		if (st_ff.bus_st == PRF_ST_DATA && st_ff.wr) begin
			case (st_ff.addr)
				`PRF_OFS_FILT_SET: wset = I_HWDATA;
				`PRF_OFS_FILT_CLR: wclr = I_HWDATA;
				default: begin
				end
			endcase
		end
		if (addr_ph) begin
			nxt_st.bus_st = PRF_ST_DATA;
			nxt_st.wr     = I_HWRITE;
			nxt_st.addr   = I_HADDR[11:0];
		end else if (I_HREADY) begin
			nxt_st.bus_st = PRF_ST_IDLE;
		end

		// RULE4 - set and clear ports
		// RULE7 - zero bits leave filter alone
		nxt_st.filt = (st_ff.filt | wset) & ~wclr;

		// RULE8 - run only moved by software
		if (dph_wr_hit(st_ff, `PRF_OFS_CTX_SET)) begin
			if (I_HWDATA[`PRF_BIT_RUN])
				nxt_st.run = 1'b1;
			if (I_HWDATA[`PRF_BIT_WAKE])
				nxt_st.wake = 1'b1;
		end
		if (dph_wr_hit(st_ff, `PRF_OFS_CTX_CLR)) begin
			if (I_HWDATA[`PRF_BIT_RUN])
				nxt_st.run = 1'b0;
		end
		// RULE9 - fetch clears wake, fetch beats software set
		if (I_DESC_FETCH) begin
			nxt_st.wake = 1'b0;
			ev[`PRF_IRQ_FETCH] = 1'b1;
		end
		// RULE10 - dead set on error, cleared with run
		if (st_ff.run && !nxt_st.run)
			nxt_st.dead = 1'b0;
		if (I_FATAL_ERR) begin
			nxt_st.dead = 1'b1;
			ev[`PRF_IRQ_DEAD] = 1'b1;
		end
		nxt_st.active = I_ACTIVE;
		// RULE11 - speed and event code capture
		if (I_PKT_DONE) begin
			nxt_st.spd = I_PKT_SPD;
			nxt_st.evt = I_PKT_EVT;
		end

		// RULE1 - recheck node after async filter
		// RULE2 - disabled node falls back to async
		// RULE3 - bit index equals node number
		nxt_st.route_vld  = I_REQ_VLD && I_REQ_ASYNC_OK;
		nxt_st.route_phys = I_REQ_VLD && I_REQ_ASYNC_OK && node_ok;
		if (I_REQ_VLD && I_REQ_ASYNC_OK) begin
			ev[`PRF_IRQ_PHYS]  = node_ok;
			ev[`PRF_IRQ_ASYNC] = !node_ok;
		end

		// Read data, decided in address phase
		if (addr_ph && !I_HWRITE) begin
			case (I_HADDR[11:0])
				// RULE7 - both ports read the filter
				`PRF_OFS_FILT_SET,
				`PRF_OFS_FILT_CLR: rd_val = st_ff.filt;
				// RULE5 - upper bound always zero
				`PRF_OFS_UPPER:    rd_val = 32'h0000_0000;
				// RULE6 - upper half zero via ctx_word
				`PRF_OFS_CTX_SET,
				`PRF_OFS_CTX_CLR:  rd_val = ctx_word(st_ff);
				`PRF_OFS_IRQ_STAT: rd_val = {28'h0000000, st_ff.irq_stat};
				`PRF_OFS_IRQ_MASK: rd_val = {28'h0000000, st_ff.irq_mask};
				default:           rd_val = 32'h0000_0000;
			endcase
		end
		nxt_st.rdata = rd_val;

		// Interrupts: read clears, a new event in the same cycle wins
		if (addr_ph && !I_HWRITE && I_HADDR[11:0] == `PRF_OFS_IRQ_STAT)
			nxt_st.irq_stat = 4'h0;
		nxt_st.irq_stat = nxt_st.irq_stat | ev;
		if (dph_wr_hit(st_ff, `PRF_OFS_IRQ_MASK))
			nxt_st.irq_mask = I_HWDATA[3:0];
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
		nxt_st.fetch_ack = I_DESC_FETCH;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st_ff        <= '0;
			st_ff.filt   <= `PRF_FILT_RST;
			st_ff.bus_st <= PRF_ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign O_HRDATA     = st_ff.rdata;
	assign O_HREADYOUT  = 1'b1;
	assign O_HRESP      = 1'b0;
	assign O_ROUTE_VLD  = st_ff.route_vld;
	assign O_ROUTE_PHYS = st_ff.route_phys;
	assign O_CTX_RUN    = st_ff.run;
	assign O_CTX_WAKE   = st_ff.wake;
	assign O_IRQ        = st_ff.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	// ----------------------------------------
	// Check helpers
	// ----------------------------------------
	logic rd_stat;
	logic evt_any;
	assign rd_stat = addr_ph && !I_HWRITE && (I_HADDR[11:0] == `PRF_OFS_IRQ_STAT);
	assign evt_any = I_DESC_FETCH || I_FATAL_ERR || (I_REQ_VLD && I_REQ_ASYNC_OK);

	AST_ROUTE_PHYS: assert property ( // RULE1
		I_REQ_VLD && I_REQ_ASYNC_OK && !I_REQ_NODE[5] && st_ff.filt[I_REQ_NODE[4:0]]
		|=> O_ROUTE_VLD && O_ROUTE_PHYS) else $error("enabled node not routed physically");
	AST_ROUTE_ASYNC: assert property ( // RULE2
		I_REQ_VLD && I_REQ_ASYNC_OK && !st_ff.filt[I_REQ_NODE[4:0]]
		|=> O_ROUTE_VLD && !O_ROUTE_PHYS) else $error("disabled node not sent to async");
	AST_NODE_MAP: assert property ( // RULE3
		O_ROUTE_PHYS |-> $past(st_ff.filt[I_REQ_NODE[4:0]])) else $error("wrong node bit");
	AST_FILT_SET: assert property ( // RULE4
		st_ff.bus_st == PRF_ST_DATA && st_ff.wr && st_ff.addr == `PRF_OFS_FILT_SET
		|=> (st_ff.filt & $past(I_HWDATA)) == $past(I_HWDATA)) else $error("set port failed");
	AST_FILT_CLR: assert property ( // RULE4
		st_ff.bus_st == PRF_ST_DATA && st_ff.wr && st_ff.addr == `PRF_OFS_FILT_CLR
		|=> (st_ff.filt & $past(I_HWDATA)) == 32'h0000_0000) else $error("clear port failed");
	AST_UPPER_ZERO: assert property ( // RULE5
		I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE && I_HADDR[11:0] == `PRF_OFS_UPPER
		|=> O_HRDATA == 32'h0000_0000) else $error("upper bound not zero");
	AST_CTX_HI_ZERO: assert property ( // RULE6
		I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE && I_HADDR[11:0] == `PRF_OFS_CTX_SET
		|=> O_HRDATA[31:16] == 16'h0000 && O_HRDATA[15] == $past(st_ff.run))
		else $error("context read wrong");
	AST_FILT_READ: assert property ( // RULE7
		I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE && I_HADDR[11:0] == `PRF_OFS_FILT_CLR
		|=> O_HRDATA == $past(st_ff.filt)) else $error("filter read wrong");
	AST_RUN_SW_ONLY: assert property ( // RULE8
		$changed(O_CTX_RUN) && !$past(I_RST)
		|-> $past(st_ff.wr && st_ff.bus_st == PRF_ST_DATA))
		else $error("run changed without software");
	AST_WAKE_FETCH: assert property ( // RULE9
		I_DESC_FETCH |=> !O_CTX_WAKE) else $error("wake not cleared on fetch");
	AST_DEAD_ERR: assert property ( // RULE10
		I_FATAL_ERR |=> st_ff.dead ##0 st_ff.active == $past(I_ACTIVE)) else $error("dead not set");
	AST_SPD_CAP: assert property ( // RULE11
		I_PKT_DONE |=> st_ff.spd == $past(I_PKT_SPD) && st_ff.evt == $past(I_PKT_EVT))
		else $error("speed or event code not captured");
	AST_NO_ROUTE: assert property ( // RULE1
		!(I_REQ_VLD && I_REQ_ASYNC_OK) |=> !O_ROUTE_VLD && !O_ROUTE_PHYS)
		else $error("route result without a checked request");
	AST_HIGH_NODE: assert property ( // RULE3
		I_REQ_VLD && I_REQ_ASYNC_OK && I_REQ_NODE[5] |=> O_ROUTE_VLD && !O_ROUTE_PHYS)
		else $error("high node routed physically");
	AST_FILT_HOLD: assert property ( // RULE7
		!dph_wr_hit(st_ff, `PRF_OFS_FILT_SET) && !dph_wr_hit(st_ff, `PRF_OFS_FILT_CLR)
		|=> $stable(st_ff.filt)) else $error("filter moved without a port write");
	AST_RUN_CLR: assert property ( // RULE8
		dph_wr_hit(st_ff, `PRF_OFS_CTX_CLR) && I_HWDATA[`PRF_BIT_RUN] |=> !O_CTX_RUN)
		else $error("run not cleared by software");
	AST_WAKE_SET: assert property ( // RULE9
		dph_wr_hit(st_ff, `PRF_OFS_CTX_SET) && I_HWDATA[`PRF_BIT_WAKE] && !I_DESC_FETCH
		|=> O_CTX_WAKE) else $error("wake not set by software");
	AST_FETCH_ACK: assert property ( // RULE9
		st_ff.fetch_ack |-> !O_CTX_WAKE && st_ff.irq_stat[`PRF_IRQ_FETCH])
		else $error("fetch left wake set or raised no event");
	AST_DEAD_CLR: assert property ( // RULE10
		st_ff.run && dph_wr_hit(st_ff, `PRF_OFS_CTX_CLR) && I_HWDATA[`PRF_BIT_RUN]
		&& !I_FATAL_ERR |=> !st_ff.dead) else $error("dead not cleared with run");
	AST_CODE_HOLD: assert property ( // RULE11
		!I_PKT_DONE |=> $stable(st_ff.spd) && $stable(st_ff.evt))
		else $error("speed or event code moved without a packet");
	AST_STAT_STICKY: assert property ( // RULE10
		!rd_stat |=> (st_ff.irq_stat & $past(st_ff.irq_stat)) == $past(st_ff.irq_stat))
		else $error("status bit lost without a read");
	AST_STAT_RDCLR: assert property ( // RULE10
		rd_stat && !evt_any |=> st_ff.irq_stat == 4'h0)
		else $error("status not cleared by read");
	AST_IRQ_DROP: assert property ( // RULE10
		rd_stat && !evt_any |=> !O_IRQ) else $error("interrupt stayed after status read");
	AST_RD_IDLE: assert property ( // RULE7
		!(addr_ph && !I_HWRITE) |=> O_HRDATA == 32'h0000_0000)
		else $error("read data left standing");
	AST_MASK_WR: assert property ( // RULE10
		dph_wr_hit(st_ff, `PRF_OFS_IRQ_MASK) |=> st_ff.irq_mask == $past(I_HWDATA[3:0]))
		else $error("mask write lost");

	COV_PHYS: cover property (O_ROUTE_VLD && O_ROUTE_PHYS);
	COV_ASYNC: cover property (O_ROUTE_VLD && !O_ROUTE_PHYS);
	COV_DEAD: cover property (st_ff.dead && st_ff.run ##1 !st_ff.run);
	COV_IRQ: cover property (O_IRQ);
	COV_RDCLR: cover property (rd_stat && O_IRQ);

endmodule : prf_filter
`default_nettype wire

// [hw/prf_pkg.sv]
// Types of the physical request filter block
package prf_pkg;
	typedef enum logic [1:0] {
		PRF_ST_IDLE = 2'b00,
		PRF_ST_DATA = 2'b01
	} prf_bus_st_t;

	typedef struct packed {
		prf_bus_st_t bus_st;
		logic        wr;
		logic [11:0] addr;
		logic [31:0] filt;
		logic        run;
		logic        wake;
		logic        dead;
		logic        active;
		logic [2:0]  spd;
		logic [4:0]  evt;
		logic [3:0]  irq_stat;
		logic [3:0]  irq_mask;
		logic [31:0] rdata;
		logic        irq;
		logic        route_vld;
		logic        route_phys;
		logic        fetch_ack;
	} prf_state_t;
endpackage : prf_pkg

// [sim/phys_request_filter_low_ctx_ctrl_tb.sv]
// Self-checking bench of the physical request filter block
`timescale 1ns/1ps
`default_nettype none
module phys_request_filter_low_ctx_ctrl_tb;
	logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic        fetch = 1'b0, fatal = 1'b0, act = 1'b0, done = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [2:0]  spd = 3'h0, hsize = 3'h0;
	logic [4:0]  evt = 5'h00;
	wire logic [31:0] hrdata;
	wire logic        hready, hresp, rvld, rphys, run, wake, irq, vld, aok;
	wire logic [5:0]  node;
	int          fail_count = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	prf_node_model nm (.i_clk(clk), .o_vld(vld), .o_node(node), .o_aok(aok));
	prf_filter DUT (.I_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
		.I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
		.I_REQ_VLD(vld), .I_REQ_NODE(node), .I_REQ_ASYNC_OK(aok), .O_ROUTE_VLD(rvld),
		.O_ROUTE_PHYS(rphys), .I_DESC_FETCH(fetch), .I_FATAL_ERR(fatal),
		.I_ACTIVE(act), .I_PKT_DONE(done), .I_PKT_SPD(spd), .I_PKT_EVT(evt),
		.O_CTX_RUN(run), .O_CTX_WAKE(wake), .O_IRQ(irq));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// The answer is taken at the rising edge that samples ready high
	task automatic wait_rdy;
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (hready === 1'b1) break;
		end
		if (i == 20) begin
			fail_count++;
			final_report();
		end
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : bus
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
		chk({31'h0, hresp}, 32'h0);
	endtask : rdc
	task automatic rq(input logic [5:0] n, input logic a, input logic ev, input logic ep);
		nm.send(n, a);
		@(negedge clk);
		chk({30'h0, rvld, rphys}, {30'h0, ev, ep});
	endtask : rq
	task automatic pulse_ctx;
		@(posedge clk);
		fatal <= 1'b1;
		act <= 1'b1;
		done <= 1'b1;
		spd <= 3'h2;
		evt <= 5'h11;
		@(posedge clk);
		fatal <= 1'b0;
		done <= 1'b0;
	endtask : pulse_ctx
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic sc_filter;
		rdc(12'h118, 32'hFFFFFFFF, 32'h0);
		rdc(12'h120, 32'hFFFFFFFF, 32'h0);
		bus(1'b1, 12'h118, 32'h80000001);
		bus(1'b1, 12'h118, 32'h0);
		rdc(12'h11C, 32'hFFFFFFFF, 32'h80000001);
		bus(1'b1, 12'h11C, 32'h00000001);
		bus(1'b1, 12'h11C, 32'h0);
		rdc(12'h118, 32'hFFFFFFFF, 32'h80000000);
		bus(1'b1, 12'h118, 32'h00000001);
		bus(1'b1, 12'h120, 32'hFFFFFFFF);
		rdc(12'h120, 32'hFFFFFFFF, 32'h0);
	endtask : sc_filter
	task automatic sc_route;
		rq(6'd0, 1'b1, 1'b1, 1'b1);
		rq(6'd31, 1'b1, 1'b1, 1'b1);
		rq(6'd1, 1'b1, 1'b1, 1'b0);
		rq(6'd32, 1'b1, 1'b1, 1'b0);
		rq(6'd31, 1'b0, 1'b0, 1'b0);
	endtask : sc_route
	task automatic sc_ctx;
		bus(1'b1, 12'h180, 32'hFFFFFFFF);
		rdc(12'h180, 32'hFFFF9C00, 32'h00009000);
		chk({30'h0, run, wake}, 32'h3);
		@(posedge clk);
		fetch <= 1'b1;
		@(posedge clk);
		fetch <= 1'b0;
		rdc(12'h180, 32'h00001000, 32'h0);
		pulse_ctx();
		rdc(12'h180, 32'hFFFFFFFF, 32'h00008C51);
		bus(1'b1, 12'h184, 32'h00008000);
		rdc(12'h180, 32'hFFFF9C00, 32'h00000400);
		chk({31'h0, run}, 32'h0);
	endtask : sc_ctx
	task automatic sc_irq;
		int i;
		rdc(12'h130, 32'hFFFFFFFF, 32'h0000000F);
		bus(1'b1, 12'h134, 32'h00000001);
		rq(6'd1, 1'b1, 1'b1, 1'b0);
		repeat (3) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		rq(6'd0, 1'b1, 1'b1, 1'b1);
		for (i = 0; i < 5 && irq !== 1'b1; i++) @(negedge clk);
		chk({31'h0, irq}, 32'h1);
		rdc(12'h130, 32'h00000001, 32'h1);
		repeat (3) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		rdc(12'h200, 32'hFFFFFFFF, 32'h0);
	endtask : sc_irq
	// Reset in mid-run must clear run and the filter
	task automatic sc_reset;
		bus(1'b1, 12'h180, 32'h00008000);
		bus(1'b1, 12'h118, 32'hFFFFFFFF);
		chk({31'h0, run}, 32'h1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk({31'h0, run}, 32'h0);
		rdc(12'h11C, 32'hFFFFFFFF, 32'h0);
	endtask : sc_reset
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		sc_filter();
		sc_route();
		sc_ctx();
		sc_irq();
		sc_reset();
		final_report();
	end
endmodule : phys_request_filter_low_ctx_ctrl_tb
`default_nettype wire

// [sim/prf_node_model.sv]
// Remote node model issuing physical requests to the filter
`timescale 1ns/1ps
`default_nettype none
module prf_node_model (
	// Clock
	input  wire logic       i_clk,
	// Request out
	output logic            o_vld,
	output logic [5:0]      o_node,
	output logic            o_aok
);
	initial begin
		o_vld = 1'b0;
		o_node = 6'h00;
		o_aok = 1'b0;
	end
	task automatic send(input logic [5:0] n, input logic a);
		@(posedge i_clk);
		o_vld <= 1'b1;
		o_node <= n;
		o_aok <= a;
		@(posedge i_clk);
		o_vld <= 1'b0;
		// Stale values are inverted so a late sample cannot pass by luck
		o_node <= ~n;
		o_aok <= ~a;
	endtask : send
endmodule : prf_node_model
`default_nettype wire
